// ==== logic/ptpc_defs.vh ====
// Constants for the precision-time capture and compare controller.
// Assumes inclusion by bare name from the design file that uses them.
`ifndef PTPC_DEFS_VH
`define PTPC_DEFS_VH

// APB byte addresses of the register words.
`define PTPC_ADDR_SYS_STS 12'h180
`define PTPC_ADDR_SYS_EN 12'h184
`define PTPC_ADDR_TGT_HI 12'h188
`define PTPC_ADDR_TGT_LO 12'h18c
`define PTPC_ADDR_RLD_HI 12'h190
`define PTPC_ADDR_RLD_LO 12'h194
`define PTPC_ADDR_SYSTEM_INTERRUPT_STATUS_EN 12'h198
`define PTPC_ADDR_INT_CLR 12'h1a0
`define PTPC_ADDR_P0_CAP_HI 12'h1a4
`define PTPC_ADDR_P0_CAP_LO 12'h1a8
`define PTPC_ADDR_P0_CAP_ID 12'h1ac
`define PTPC_ADDR_PIN8_CAP_HI 12'h1b0
`define PTPC_ADDR_PIN8_CAP_LO 12'h1b4
`define PTPC_ADDR_PIN9_CAP_HI 12'h1b8
`define PTPC_ADDR_PIN9_CAP_LO 12'h1bc
`define PTPC_ADDR_CAP_CFG 12'h1c0

// Status bit positions; enables sit at the status position plus this offset.
`define PTPC_STS_TIMER 0
`define PTPC_STS_PIN8 1
`define PTPC_STS_PIN9 2
`define PTPC_STS_P0_TX 3
`define PTPC_STS_P0_RX 4
`define PTPC_EN_OFFSET 16
`define PTPC_SYS_EVT_BIT 29

// Capture configuration field positions.
`define PTPC_CFG_RELOAD 0
`define PTPC_CFG_MODE8_LSB 1
`define PTPC_CFG_MODE9_LSB 3
`define PTPC_CFG_LOCK8 5
`define PTPC_CFG_LOCK9 6
`define PTPC_CFG_LOCK_P0_TX 8
`define PTPC_CFG_RESET 9'h160

// Event pin modes.
`define PTPC_MODE_PULSE 2'h0
`define PTPC_MODE_TOGGLE 2'h1
`define PTPC_MODE_LEVEL 2'h2

// Pulse width in ns and derived cycle count, rounded up.
`define PTPC_CLK_PERIOD_NS 10
`define PTPC_PULSE_NS 100
`define PTPC_PULSE_CYC ((`PTPC_PULSE_NS + `PTPC_CLK_PERIOD_NS - 1) / `PTPC_CLK_PERIOD_NS)

`endif

// ==== logic/ptpc_capture_compare.v ====
// Precision-time capture hold-off, clock-target compare and event pin control.
// Assumes an outside 64-bit clock counter on clk_sys and an APB master.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ptpc_defs.vh"

module ptpc_capture_compare (
    input wire clk_sys, // System clock, 100 MHz.
    input wire rst_b, // Asynchronous reset, active low.
    input wire psel, // APB select.
    input wire penable, // APB access phase.
    input wire pwrite, // APB direction, high for write.
    input wire [11:0] paddr, // APB byte address.
    input wire [31:0] pwdata, // APB write data.
    output wire pready, // APB ready, always high.
    output reg [31:0] prdata, // APB read data.
    output wire pslverr, // APB error on unmapped address.
    input wire [63:0] clock_now, // Running timing clock.
    input wire p0_ingress_capture, // Port 0 frame into the fabric matched.
    input wire p0_egress_capture, // Port 0 frame from the fabric matched.
    input wire [3:0] other_port_capture, // Port 2 rx, 2 tx, 1 rx, 1 tx events.
    input wire [15:0] p0_seq_id, // Sequence identifier of the matched frame.
    input wire [15:0] p0_source_identity, // Source identity of the matched frame.
    input wire [1:0] pin_in, // Pins 9 and 8 as inputs, asynchronous.
    input wire [1:0] pin_oe_en, // Pin output enable from pin config.
    input wire pin8_event_polarity, // Pin 8 active level, high for active high.
    input wire pin9_event_polarity, // Pin 9 active level, high for active high.
    input wire [1:0] pin_buffer_type_in, // Buffer type bits from pin config.
    output wire [1:0] pin_out, // Pins 9 and 8 output level.
    output wire [1:0] pin_out_en_b, // Pins 9 and 8 output enable, active low.
    output reg [1:0] pin_buffer_type, // Buffer type to the pin cells.
    output reg timing_event_summary, // Aggregated enabled timing status.
    output wire irq // Level interrupt to the system.
);

    // ----------------------------------------------------------------
    // State declarations
    // ----------------------------------------------------------------
    reg [8:0] system_interrupt_status;
    reg [8:0] int_en;
    reg [8:0] cap_cfg;
    reg sys_evt_en;
    reg [31:0] tgt_hi;
    reg [31:0] tgt_lo;
    reg [31:0] rld_hi;
    reg [31:0] rld_lo;
    reg [63:0] p0_cap_clock;
    reg [15:0] p0_cap_seq;
    reg [15:0] p0_cap_ident;
    reg [1:0] pin_s1;
    reg [1:0] pin_s2;
    reg [1:0] pin_s3;
    wire [127:0] pin_cap_bus;
    wire [63:0] target;
    wire cmp_hit;
    wire [1:0] pin_edge;
    wire wr_en;
    wire rd_setup;
    wire [8:0] set_bits;
    wire [8:0] clr_bits;
    wire [63:0] next_target;
    wire [1:0] pin_pol;
    localparam [31:0] pulse_load = `PTPC_PULSE_CYC;

    // Returns one when the address names a mapped register word.
    function addr_mapped;
        input [11:0] a;
        begin
            case (a)
                `PTPC_ADDR_SYS_STS, `PTPC_ADDR_SYS_EN, `PTPC_ADDR_TGT_HI,
                `PTPC_ADDR_TGT_LO, `PTPC_ADDR_RLD_HI, `PTPC_ADDR_RLD_LO,
                `PTPC_ADDR_SYSTEM_INTERRUPT_STATUS_EN, `PTPC_ADDR_INT_CLR, `PTPC_ADDR_P0_CAP_HI,
                `PTPC_ADDR_P0_CAP_LO, `PTPC_ADDR_P0_CAP_ID, `PTPC_ADDR_PIN8_CAP_HI,
                `PTPC_ADDR_PIN8_CAP_LO, `PTPC_ADDR_PIN9_CAP_HI,
                `PTPC_ADDR_PIN9_CAP_LO, `PTPC_ADDR_CAP_CFG:
                    addr_mapped = 1'b1;
                default:
                    addr_mapped = 1'b0;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // APB handshake
    // ----------------------------------------------------------------

    // The slave never stalls; writes land at the access edge.
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_mapped(paddr);
    assign wr_en = psel & penable & pwrite & addr_mapped(paddr);
    assign rd_setup = psel & ~penable & ~pwrite;

    // Read data is registered in the setup cycle so it is stable in access.
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prdata <= 32'h0;
        end
        else if (rd_setup)
        begin
            case (paddr)
                `PTPC_ADDR_SYS_STS: prdata <= {2'h0, timing_event_summary, 29'h0};
                `PTPC_ADDR_SYS_EN: prdata <= {2'h0, sys_evt_en, 29'h0};
                `PTPC_ADDR_TGT_HI: prdata <= tgt_hi;
                `PTPC_ADDR_TGT_LO: prdata <= tgt_lo;
                `PTPC_ADDR_RLD_HI: prdata <= rld_hi;
                `PTPC_ADDR_RLD_LO: prdata <= rld_lo;
                `PTPC_ADDR_SYSTEM_INTERRUPT_STATUS_EN: prdata <= {7'h0, int_en, 7'h0, system_interrupt_status};
                `PTPC_ADDR_P0_CAP_HI: prdata <= p0_cap_clock[63:32];
                `PTPC_ADDR_P0_CAP_LO: prdata <= p0_cap_clock[31:0];
                `PTPC_ADDR_P0_CAP_ID: prdata <= {p0_cap_ident, p0_cap_seq};
                `PTPC_ADDR_PIN8_CAP_HI: prdata <= pin_cap_bus[63:32];
                `PTPC_ADDR_PIN8_CAP_LO: prdata <= pin_cap_bus[31:0];
                `PTPC_ADDR_PIN9_CAP_HI: prdata <= pin_cap_bus[127:96];
                `PTPC_ADDR_PIN9_CAP_LO: prdata <= pin_cap_bus[95:64];
                `PTPC_ADDR_CAP_CFG: prdata <= {23'h0, cap_cfg};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Configuration and enable registers
    // ----------------------------------------------------------------

    // Software-owned control words; reserved config bit 7 stays zero.
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cap_cfg <= `PTPC_CFG_RESET;
            int_en <= 9'h0;
            sys_evt_en <= 1'b0;
            rld_hi <= 32'h0;
            rld_lo <= 32'h0;
        end
        else if (wr_en)
        begin
            if (paddr == `PTPC_ADDR_CAP_CFG)
            begin
                cap_cfg <= pwdata[8:0] & 9'h17f;
            end
            if (paddr == `PTPC_ADDR_SYSTEM_INTERRUPT_STATUS_EN)
            begin
                int_en <= pwdata[24:16];
            end
            if (paddr == `PTPC_ADDR_SYS_EN)
            begin
                sys_evt_en <= pwdata[`PTPC_SYS_EVT_BIT];
            end
            if (paddr == `PTPC_ADDR_RLD_HI)
            begin
                rld_hi <= pwdata;
            end
            if (paddr == `PTPC_ADDR_RLD_LO)
            begin
                rld_lo <= pwdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Clock target compare
    // ----------------------------------------------------------------

    // In add mode with a nonzero rld_lo the target moves on every hit with no target write in the same cycle, so each crossing makes one event.
    assign target = {tgt_hi, tgt_lo};
    assign cmp_hit = (clock_now >= target);
    assign next_target = cap_cfg[`PTPC_CFG_RELOAD] ? {rld_hi, rld_lo}
                       : target + {32'h0, rld_lo};

    // Software writes win over the hardware update in the same cycle.
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tgt_hi <= 32'hffffffff;
            tgt_lo <= 32'hffffffff;
        end
        else if (wr_en && paddr == `PTPC_ADDR_TGT_HI)
        begin
            tgt_hi <= pwdata;
        end
        else if (wr_en && paddr == `PTPC_ADDR_TGT_LO)
        begin
            tgt_lo <= pwdata;
        end
        else if (cmp_hit)
        begin
            tgt_hi <= next_target[63:32];
            tgt_lo <= next_target[31:0];
        end
    end

    // ----------------------------------------------------------------
    // Pin input synchroniser and edge detect
    // ----------------------------------------------------------------

    // Two stages resync the pins; the third stage only feeds edge detect.
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_s1 <= 2'h0;
            pin_s2 <= 2'h0;
            pin_s3 <= 2'h0;
        end
        else
        begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    assign pin_edge = pin_s2 & ~pin_s3;
    assign pin_pol = {pin9_event_polarity, pin8_event_polarity};

    // ----------------------------------------------------------------
    // Port 0 transmit capture
    // ----------------------------------------------------------------

    // Ingress into the fabric counts as transmit for port 0.
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            p0_cap_clock <= 64'h0;
            p0_cap_seq <= 16'h0;
            p0_cap_ident <= 16'h0;
        end
        else if (p0_ingress_capture &&
                 !(cap_cfg[`PTPC_CFG_LOCK_P0_TX] && system_interrupt_status[`PTPC_STS_P0_TX]))
        begin
            p0_cap_clock <= clock_now;
            p0_cap_seq <= p0_seq_id;
            p0_cap_ident <= p0_source_identity;
        end
    end

    // ----------------------------------------------------------------
    // Event pins: capture hold and compare output
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : gen_pin
            reg [63:0] cap;
            reg [3:0] pulse_cnt;
            reg toggle_lvl;
            reg raw;
            reg drv;
            wire [1:0] mode;
            wire lock;
            wire held;

            assign mode = gi ? cap_cfg[`PTPC_CFG_MODE9_LSB +: 2]
                             : cap_cfg[`PTPC_CFG_MODE8_LSB +: 2];
            assign lock = gi ? cap_cfg[`PTPC_CFG_LOCK9] : cap_cfg[`PTPC_CFG_LOCK8];
            assign held = lock & system_interrupt_status[`PTPC_STS_PIN8 + gi];

            // Pin capture store, refused while the hold is active.
            always @(posedge clk_sys or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    cap <= 64'h0;
                end
                else if (pin_edge[gi] && !held)
                begin
                    cap <= clock_now;
                end
            end

            // Pulse counter, toggle level and the selected raw output.
            always @(posedge clk_sys or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    pulse_cnt <= 4'h0;
                    toggle_lvl <= 1'b0;
                end
                else
                begin
                    if (cmp_hit && mode == `PTPC_MODE_PULSE)
                    begin
                        pulse_cnt <= pulse_load[3:0];
                    end
                    else if (pulse_cnt != 4'h0)
                    begin
                        pulse_cnt <= pulse_cnt - 4'h1;
                    end
                    if (cmp_hit && mode == `PTPC_MODE_TOGGLE)
                    begin
                        toggle_lvl <= ~toggle_lvl;
                    end
                end
            end

            // Mode select of the active-high level before polarity.
            always @*
            begin
                case (mode)
                    `PTPC_MODE_PULSE: raw = (pulse_cnt != 4'h0);
                    `PTPC_MODE_TOGGLE: raw = toggle_lvl;
                    `PTPC_MODE_LEVEL: raw = system_interrupt_status[`PTPC_STS_TIMER];
                    default: raw = 1'b0;
                endcase
            end

            // Registered pin drive with polarity applied.
            always @(posedge clk_sys or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    drv <= 1'b0;
                end
                else
                begin
                    drv <= pin_pol[gi] ? raw : ~raw;
                end
            end

            assign pin_cap_bus[gi * 64 +: 64] = cap;
            assign pin_out[gi] = drv;
            assign pin_out_en_b[gi] = ~pin_oe_en[gi];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Interrupt status, clear and aggregation
    // ----------------------------------------------------------------

    // Event sources in status order 8..0; enables do not gate them.
    assign set_bits = {other_port_capture, p0_egress_capture, p0_ingress_capture,
                       pin_edge, cmp_hit};
    assign clr_bits = !wr_en ? 9'h0
                    : (paddr == `PTPC_ADDR_SYSTEM_INTERRUPT_STATUS_EN || paddr == `PTPC_ADDR_INT_CLR)
                    ? pwdata[8:0] : 9'h0;

    // A set in the same cycle as a clear wins.
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            system_interrupt_status <= 9'h0;
        end
        else
        begin
            system_interrupt_status <= (system_interrupt_status & ~clr_bits) | set_bits;
        end
    end

    // Summary and buffer type are registered toward the system.
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            timing_event_summary <= 1'b0;
            pin_buffer_type <= 2'h0;
        end
        else
        begin
            timing_event_summary <= |(system_interrupt_status & int_en);
            pin_buffer_type <= pin_buffer_type_in;
        end
    end

    assign irq = timing_event_summary & sys_evt_en;

endmodule

`default_nettype wire

// ==== test/ptpc_checker.sv ====
// Port checker for the capture and compare controller.
// Assumes one clock domain and a bind onto the design top.
`timescale 1ns/100ps
`default_nettype none
`include "ptpc_defs.vh"

module ptpc_checker (
    input wire logic clk_sys, // System clock.
    input wire logic rst_b, // Reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access.
    input wire logic pwrite, // APB direction.
    input wire logic [11:0] paddr, // APB address.
    input wire logic pready, // APB ready.
    input wire logic [31:0] prdata, // APB read data.
    input wire logic pslverr, // APB error.
    input wire logic [1:0] pin_oe_en, // Pin enables in.
    input wire logic [1:0] pin_buffer_type_in, // Buffer type in.
    input wire logic [1:0] pin_out, // Pin levels.
    input wire logic [1:0] pin_out_en_b, // Pin enables out.
    input wire logic [1:0] pin_buffer_type, // Buffer type out.
    input wire logic timing_event_summary, // Summary flag.
    input wire logic irq // Interrupt.
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    // Each property ties an output to its cause at the inputs or at another output.
    property p_oe_follow;
        pin_out_en_b == ~pin_oe_en;
    endproperty
    a_oe_follow:
        assert property (p_oe_follow) else $error("pin enable mismatch");
    property p_buf_copy;
        $past(rst_b) |-> pin_buffer_type == $past(pin_buffer_type_in);
    endproperty
    a_buf_copy:
        assert property (p_buf_copy) else $error("buffer type not copied");
    property p_irq_src;
        irq |-> timing_event_summary;
    endproperty
    a_irq_src:
        assert property (p_irq_src) else $error("irq without summary");
    property p_irq_hold;
        !(psel && penable && pwrite) ##1 $stable(timing_event_summary) |-> $stable(irq);
    endproperty
    a_irq_hold:
        assert property (p_irq_hold) else $error("irq moved without cause");
    property p_map_sts;
        psel && penable && paddr == `PTPC_ADDR_SYSTEM_INTERRUPT_STATUS_EN |-> !pslverr;
    endproperty
    a_map_sts:
        assert property (p_map_sts) else $error("status word refused");
    property p_err_phase;
        pslverr |-> psel && penable;
    endproperty
    a_err_phase:
        assert property (p_err_phase) else $error("error outside access");
    property p_err_rd0;
        psel && penable && !pwrite && pslverr |-> prdata == 32'h0;
    endproperty
    a_err_rd0:
        assert property (p_err_rd0) else $error("refused read not zero");
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready:
        assert property (p_ready) else $error("access not ready");
    property p_err_unmap;
        psel && penable && paddr == 12'h0f0 |-> pslverr;
    endproperty
    a_err_unmap:
        assert property (p_err_unmap) else $error("unmapped access not refused");
    c_irq: cover property (irq);
    c_err: cover property (pslverr);
    c_p8: cover property ($rose(pin_out[0]));
    c_p9: cover property ($rose(pin_out[1]));
endmodule

bind ptpc_capture_compare ptpc_checker ptpc_checker_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pin_oe_en(pin_oe_en),
    .pin_buffer_type_in(pin_buffer_type_in), .pin_out(pin_out), .pin_out_en_b(pin_out_en_b),
    .pin_buffer_type(pin_buffer_type), .timing_event_summary(timing_event_summary), .irq(irq));
`default_nettype wire

// ==== test/ptp_capture_compare_ctrl_tb.sv ====
// Self-checking bench for the capture and compare controller.
// Assumes the design and its checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "ptpc_defs.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
    $display("unexpected t=%0t got %h exp %h", $time, a, e); end end

module ptp_capture_compare_ctrl_tb;
    logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic p0_in = 0, p0_eg = 0, pol8 = 1, pol9 = 1;
    logic [3:0] oth = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rs = 5474, v, s;
    logic [63:0] clock_now = 0, tgt = '1, rld = 0, a, b;
    logic [15:0] seq = 0, sid = 0;
    logic [1:0] pin_in = 0, oe = 0, bufin = 0;
    wire pready, pslverr, summ, irq;
    wire [31:0] prdata;
    wire [1:0] pin_out, oe_b, buft;
    logic [31:0] q[$];
    logic [31:0] exp_rd;
    int err_total = 0, checks_done = 0, cyc = 0, n8;

    ptpc_capture_compare dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .clock_now(clock_now), .p0_ingress_capture(p0_in),
        .p0_egress_capture(p0_eg), .other_port_capture(oth), .p0_seq_id(seq),
        .p0_source_identity(sid), .pin_in(pin_in), .pin_oe_en(oe), .pin8_event_polarity(pol8),
        .pin9_event_polarity(pol9), .pin_buffer_type_in(bufin), .pin_out(pin_out),
        .pin_out_en_b(oe_b), .pin_buffer_type(buft), .timing_event_summary(summ), .irq(irq));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One APB transfer held until pready is seen high.
    task xfer(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        psel <= 0;
        penable <= 0;
    endtask
    task wr(input logic [11:0] ad, input logic [31:0] d);
        xfer(1, ad, d);
    endtask
    task rd(input logic [11:0] ad, input logic [31:0] e);
        q.push_back(e);
        xfer(0, ad, 32'h0);
    endtask
    // Pulses the frame match inputs for one cycle: {egress, ingress, other}.
    task ev(input logic [5:0] m, input logic [63:0] c);
        @(posedge clk_sys);
        clock_now <= c;
        {p0_eg, p0_in, oth} <= m;
        @(posedge clk_sys);
        {p0_eg, p0_in, oth} <= 6'h0;
        repeat (3) @(posedge clk_sys);
    endtask
    task pcap(input int p, input logic [63:0] c);
        @(posedge clk_sys);
        clock_now <= c;
        pin_in[p] <= 1;
        repeat (5) @(posedge clk_sys);
        pin_in[p] <= 0;
        repeat (5) @(posedge clk_sys);
    endtask
    // Drives the clock onto the target and counts pin 8 active cycles.
    task fire(input logic ld);
        n8 = 0;
        @(posedge clk_sys);
        clock_now <= tgt;
        tgt = ld ? rld : tgt + {32'h0, rld[31:0]};
        repeat (16)
        begin
            @(negedge clk_sys);
            n8 += pin_out[0];
        end
    endtask

    // Clock source.
    initial forever #5 clk_sys = ~clk_sys;

    // Monitor: each completed read is compared with the oldest note.
    always @(negedge clk_sys)
    begin
        if (psel && penable && !pwrite && pready)
        begin
            exp_rd = q.pop_front();
            `CHK(prdata, exp_rd)
        end
    end

    // Watchdog on total run length.
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            stop_test();
        end
    end

    // Main sequence.
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1;
        oe <= rnd();
        bufin <= rnd();
        rd(`PTPC_ADDR_CAP_CFG, 32'h160);
        rd(`PTPC_ADDR_SYSTEM_INTERRUPT_STATUS_EN, 32'h0);
        rd(12'h0f0, 32'h0);
        v = rnd() & 32'h01ff_0000;
        wr(`PTPC_ADDR_SYSTEM_INTERRUPT_STATUS_EN, v);
        rd(`PTPC_ADDR_SYSTEM_INTERRUPT_STATUS_EN, v);
        wr(`PTPC_ADDR_SYSTEM_INTERRUPT_STATUS_EN, 32'h0008_0000);
        $display("test registers done");
        ev(6'h10, 64'h0);
        rd(`PTPC_ADDR_SYSTEM_INTERRUPT_STATUS_EN, 32'h0008_0008);
        ev(6'h2f, 64'h0);
        rd(`PTPC_ADDR_SYSTEM_INTERRUPT_STATUS_EN, 32'h0008_01f8);
        rd(`PTPC_ADDR_SYS_STS, 32'h2000_0000);
        @(negedge clk_sys);
        `CHK(irq, 1'b0)
        wr(`PTPC_ADDR_SYS_EN, 32'h2000_0000);
        @(negedge clk_sys);
        `CHK(irq, 1'b1)
        wr(`PTPC_ADDR_SYSTEM_INTERRUPT_STATUS_EN, 32'h0008_0008);
        rd(`PTPC_ADDR_SYSTEM_INTERRUPT_STATUS_EN, 32'h0008_01f0);
        rd(`PTPC_ADDR_SYS_STS, 32'h0);
        @(negedge clk_sys);
        `CHK(irq, 1'b0)
        wr(`PTPC_ADDR_INT_CLR, 32'h1ff);
        $display("test interrupts done");
        // Port 0 transmit capture: held, cleared, then unheld.
        for (int k = 0; k < 4; k++)
        begin
            if (k == 3)
                wr(`PTPC_ADDR_CAP_CFG, 32'h060);
            b = {rnd(), rnd()};
            s = rnd();
            {sid, seq} <= s;
            ev(6'h10, b);
            if (k != 1)
            begin
                a = b;
                v = s;
            end
            rd(`PTPC_ADDR_P0_CAP_HI, a[63:32]);
            rd(`PTPC_ADDR_P0_CAP_LO, a[31:0]);
            rd(`PTPC_ADDR_P0_CAP_ID, v);
            if (k == 1)
                wr(`PTPC_ADDR_INT_CLR, 32'h8);
        end
        // Pin captures: first kept while held, then replaced after clear.
        for (int p = 0; p < 2; p++)
        begin
            a = {rnd(), rnd()};
            b = {rnd(), rnd()};
            pcap(p, a);
            pcap(p, b);
            rd(`PTPC_ADDR_PIN8_CAP_HI + 12'(8 * p), a[63:32]);
            rd(`PTPC_ADDR_PIN8_CAP_LO + 12'(8 * p), a[31:0]);
            wr(`PTPC_ADDR_INT_CLR, 32'h2 << p);
            pcap(p, b);
            rd(`PTPC_ADDR_PIN8_CAP_LO + 12'(8 * p), b[31:0]);
        end
        $display("test captures done");
        // Compare: pin 8 pulse, pin 9 toggle, add mode.
        wr(`PTPC_ADDR_INT_CLR, 32'h1ff);
        clock_now <= 64'h0;
        rld = {rnd() | 32'h1000_0000, rnd() | 32'h100};
        wr(`PTPC_ADDR_RLD_HI, rld[63:32]);
        wr(`PTPC_ADDR_RLD_LO, rld[31:0]);
        wr(`PTPC_ADDR_CAP_CFG, 32'h168);
        tgt = 64'h1000;
        wr(`PTPC_ADDR_TGT_HI, 32'h0);
        wr(`PTPC_ADDR_TGT_LO, 32'h1000);
        clock_now <= 64'hfff;
        rd(`PTPC_ADDR_SYSTEM_INTERRUPT_STATUS_EN, 32'h0008_0000);
        for (int k = 0; k < 2; k++)
        begin
            fire(0);
            `CHK(n8, `PTPC_PULSE_CYC)
            `CHK(pin_out[1], !k)
            rd(`PTPC_ADDR_TGT_LO, tgt[31:0]);
        end
        rd(`PTPC_ADDR_SYSTEM_INTERRUPT_STATUS_EN, 32'h0008_0001);
        // Reload mode, pin 8 level, pin 9 reserved with inverted sense.
        wr(`PTPC_ADDR_CAP_CFG, 32'h17d);
        pol9 <= 0;
        wr(`PTPC_ADDR_INT_CLR, 32'h1);
        repeat (2) @(negedge clk_sys);
        `CHK(pin_out[0], 1'b0)
        fire(1);
        `CHK(pin_out, 2'b11)
        rd(`PTPC_ADDR_TGT_HI, rld[63:32]);
        rd(`PTPC_ADDR_TGT_LO, rld[31:0]);
        $display("test compare done");
        repeat (3) @(posedge clk_sys);
        `CHK(q.size(), 0)
        stop_test();
    end
endmodule
`default_nettype wire
